/* File: hdl/ocs_pacer.sv */
// Trigger edge detection and scan clock generation.
`include "ocs_params.svh"
`default_nettype none
module ocs_pacer #(
    parameter int DIV_WIDTH = 32
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // External pins
    input  wire logic                 ext_trigger,
    input  wire logic                 ext_clock,
    // Configuration
    input  wire logic [1:0]           trig_sel,
    input  wire logic                 clk_ext_sel,
    input  wire logic [DIV_WIDTH-1:0] pace_div,
    // Sequencer state
    input  wire logic                 armed,
    input  wire logic                 running,
    // Events
    output logic                      trig_pulse,
    output logic                      tick
);
    logic                 trig_prev;
    logic                 clk_prev;
    logic [DIV_WIDTH-1:0] cnt;
    logic                 hit;
    logic                 next_trig_pulse;
    logic                 next_tick;
    logic [DIV_WIDTH-1:0] next_cnt;

    always_comb begin
        // [R19] External trigger edge
        case (trig_sel)
            `OCS_TRIG_SW:   hit = 1'b1;
            `OCS_TRIG_RISE: hit = ext_trigger & ~trig_prev;
            `OCS_TRIG_FALL: hit = ~ext_trigger & trig_prev;
            default:        hit = 1'b0;
        endcase
        next_trig_pulse = armed & hit;
        next_tick = 1'b0;
        next_cnt = '0;
        if (running) begin
            if (clk_ext_sel) begin
                next_tick = ext_clock & ~clk_prev;
            end else if (cnt + 1'b1 >= pace_div) begin
                next_tick = 1'b1;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_prev  <= 1'b0;
            clk_prev   <= 1'b0;
            cnt        <= '0;
            trig_pulse <= 1'b0;
            tick       <= 1'b0;
        end else begin
            trig_prev  <= ext_trigger;
            clk_prev   <= ext_clock;
            cnt        <= next_cnt;
            trig_pulse <= next_trig_pulse;
            tick       <= next_tick;
        end
    end

    a_rise_trigger: assert property (@(posedge clk) disable iff (!rst_n)
        armed && trig_sel == `OCS_TRIG_RISE && ext_trigger && !trig_prev
        |=> trig_pulse) // [R19]
        else $error("rising trigger edge not detected");
endmodule
`default_nettype wire

/* File: hdl/ocs_sample_ram.sv */
// Sample memory of the output FIFO with registered read data.
`default_nettype none
module ocs_sample_ram #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 131072,
    parameter int AW    = $clog2(DEPTH)
) (
    // Clock
    input  wire logic             clk,
    // Write port
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    // Read port
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

/* File: hdl/ocs_sequencer.sv */
// Output channel sequencer: APB registers, scan engine and outputs.
// Summary of operation
// [R1] Host interleaves samples in list order.
// [R2] Trigger starts scans; channels update together.
// [R3] Continuous mode runs gap-free until data ends.
// [R4] Orderly stop finishes buffer, ignores triggers.
// [R5] Abrupt stop halts at once, ignores triggers.
// [R6] Scan tick without data flags underflow.
// [R7] Outputs hold last value when starved.
// [R8] Tick during loading flags over-sample.
// [R9] Waveform length per channel within limits.
// [R10] Equal lengths; total multiple of channels.
// [R11] Waveform wraps to first sample forever.
// [R12] FIFO holds 128k samples, replayed locally.
// [R13] Analog codes are offset binary.
// [R14] Event pulse after each complete buffer.
// [R15] Repeat select picks waveform or continuous.
// [R16] Digital port: 16 lines, one list channel.
// [R17] Digital lines low after reset.
// [R18] Codes 0-3 analog, 4 digital, ascending.
// [R19] External trigger on configured edge.
// [R20] Error flags latch until host clears.
`include "ocs_params.svh"
`default_nettype none
module ocs_sequencer
    import ocs_pkg::*;
#(
    parameter int DAC_WIDTH  = 16,
    parameter int FIFO_DEPTH = `OCS_FIFO_DEPTH,
    parameter int AW         = $clog2(FIFO_DEPTH)
) (
    // APB slave
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // External pacing pins
    input  wire logic                 ext_trigger,
    input  wire logic                 ext_clock,
    // Converter and port outputs
    output logic      [DAC_WIDTH-1:0] analog_out_ch_zero,
    output logic      [DAC_WIDTH-1:0] analog_out_ch_one,
    output logic      [DAC_WIDTH-1:0] analog_out_ch_two,
    output logic      [DAC_WIDTH-1:0] analog_out_ch_three,
    output logic      [15:0]          digital_out,
    // Host event
    output logic                      buffer_done_event
);
    localparam int NCH = `OCS_NUM_CH;

    ocs_state_type  state, next_state;
    logic           repeat_one_buffer_select, next_repeat;
    logic [1:0]     trig_sel, next_trig_sel;
    logic           clk_ext_sel, next_clk_ext_sel;
    logic [4:0]     list_mask, next_list_mask;
    logic [31:0]    pace_div, next_pace_div;
    logic [AW:0]    buf_len, next_buf_len;
    logic [2:0]     ch, next_ch;
    logic           phase, next_phase;
    logic [AW-1:0]  rd_ptr, next_rd_ptr;
    logic [AW-1:0]  wr_ptr, next_wr_ptr;
    logic [AW:0]    level, next_level;
    logic [AW:0]    sample_idx, next_sample_idx;
    logic           stop_pending, next_stop_pending;
    logic           underflow, next_underflow;
    logic           oversample, next_oversample;
    logic           buf_done_flag, next_buf_done_flag;
    logic           next_buffer_done_event;
    ocs_sample_type shadow [NCH];
    ocs_sample_type next_shadow [NCH];
    ocs_sample_type out_val [NCH];
    ocs_sample_type next_out_val [NCH];
    logic [31:0]    next_prdata;
    logic           next_pready;
    logic           next_pslverr;
    ocs_sample_type ram_q;
    logic           trig_pulse;
    logic           tick;
    logic           acc;
    logic           wr;
    logic           mapped;
    logic           full;
    logic           push;
    logic           pop;
    logic           buf_end;
    logic           abrupt;
    logic           commit;
    logic           flush;
    logic           starve;
    logic [31:0]    rd_mux;

    function automatic logic [2:0] n_listed(input logic [4:0] m);
        logic [2:0] n;
        n = '0;
        for (int i = 0; i < NCH; i++) begin
            n = n + {2'b00, m[i]};
        end
        return n;
    endfunction

    // Lowest listed channel at or above the start code, NCH when none.
    function automatic logic [2:0] first_from(input logic [4:0] m,
                                              input logic [2:0] from);
        logic [2:0] r;
        r = 3'(NCH);
        for (int i = NCH - 1; i >= 0; i--) begin
            if (m[i] && 3'(i) >= from) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    ocs_pacer #(
        .DIV_WIDTH   (32)
    ) u_pacer (
        .clk         (pclk),
        .rst_n       (presetn),
        .ext_trigger (ext_trigger),
        .ext_clock   (ext_clock),
        .trig_sel    (trig_sel),
        .clk_ext_sel (clk_ext_sel),
        .pace_div    (pace_div),
        .armed       (state == OCS_ARMED),
        .running     (state == OCS_RUN || state == OCS_LOAD),
        .trig_pulse  (trig_pulse),
        .tick        (tick)
    );

    // [R12] FIFO sample storage
    ocs_sample_ram #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_ram (
        .clk   (pclk),
        .we    (push),
        .waddr (wr_ptr),
        .wdata (pwdata[15:0]),
        .raddr (rd_ptr),
        .rdata (ram_q)
    );

    always_comb begin
        acc = psel && penable;
        wr = acc && pready && pwrite;
        full = level == (AW+1)'(FIFO_DEPTH);
        mapped = paddr == `OCS_ADDR_CTRL || paddr == `OCS_ADDR_LIST
              || paddr == `OCS_ADDR_DIV || paddr == `OCS_ADDR_DATA
              || paddr == `OCS_ADDR_BUFLEN || paddr == `OCS_ADDR_STATUS
              || paddr == `OCS_ADDR_LEVEL;
        // A data write to a full FIFO waits in its access phase.
        next_pready = acc && !pready
                   && !(pwrite && paddr == `OCS_ADDR_DATA && full);
        next_pslverr = next_pready && !mapped;
        case (paddr)
            `OCS_ADDR_CTRL:   rd_mux = {24'h000000, 1'b0, clk_ext_sel,
                                        trig_sel, repeat_one_buffer_select,
                                        3'h0};
            `OCS_ADDR_LIST:   rd_mux = {27'h0000000, list_mask};
            `OCS_ADDR_DIV:    rd_mux = pace_div;
            `OCS_ADDR_BUFLEN: rd_mux = 32'(buf_len);
            `OCS_ADDR_STATUS: rd_mux = {26'h0000000, stop_pending,
                                        buf_done_flag, oversample, underflow,
                                        state == OCS_ARMED,
                                        state == OCS_RUN
                                        || state == OCS_LOAD};
            `OCS_ADDR_LEVEL:  rd_mux = 32'(level);
            default:          rd_mux = 32'h00000000;
        endcase
        next_prdata = (next_pready && !pwrite) ? rd_mux : 32'h00000000;

        next_state = state;
        next_repeat = repeat_one_buffer_select;
        next_trig_sel = trig_sel;
        next_clk_ext_sel = clk_ext_sel;
        next_list_mask = list_mask;
        next_pace_div = pace_div;
        next_buf_len = buf_len;
        next_ch = ch;
        next_phase = phase;
        next_rd_ptr = rd_ptr;
        next_wr_ptr = wr_ptr;
        next_sample_idx = sample_idx;
        next_stop_pending = stop_pending;
        next_underflow = underflow;
        next_oversample = oversample;
        next_buf_done_flag = buf_done_flag;
        next_buffer_done_event = 1'b0;
        next_shadow = shadow;
        // [R7] Hold last values
        next_out_val = out_val;
        push = 1'b0;
        pop = 1'b0;
        buf_end = 1'b0;
        abrupt = 1'b0;
        commit = 1'b0;
        flush = 1'b0;

        if (wr) begin
            case (paddr)
                `OCS_ADDR_CTRL: begin
                    // [R15] Mode select bit
                    next_repeat = pwdata[`OCS_CTRL_REPEAT];
                    next_trig_sel = pwdata[`OCS_CTRL_TSEL];
                    next_clk_ext_sel = pwdata[`OCS_CTRL_CLKEXT];
                    if (pwdata[`OCS_CTRL_START] && state == OCS_IDLE) begin
                        next_state = OCS_ARMED;
                        next_sample_idx = '0;
                        if (pwdata[`OCS_CTRL_REPEAT]) begin
                            next_rd_ptr = '0;
                        end
                    end
                    if (pwdata[`OCS_CTRL_ORDERLY] && state != OCS_IDLE) begin
                        next_stop_pending = 1'b1;
                    end
                    abrupt = pwdata[`OCS_CTRL_ABRUPT];
                    if (pwdata[`OCS_CTRL_FLUSH] && state == OCS_IDLE) begin
                        next_rd_ptr = '0;
                        next_wr_ptr = '0;
                        flush = 1'b1;
                    end
                end
                // [R18] Ascending list as mask
                `OCS_ADDR_LIST:   next_list_mask = pwdata[4:0];
                `OCS_ADDR_DIV:    next_pace_div = pwdata;
                `OCS_ADDR_BUFLEN: next_buf_len = pwdata[AW:0];
                `OCS_ADDR_DATA: begin
                    push = 1'b1;
                    next_wr_ptr = wr_ptr + 1'b1;
                end
                `OCS_ADDR_STATUS: begin
                    // [R20] Host clears latched flags
                    if (pwdata[`OCS_STAT_UNDER]) next_underflow = 1'b0;
                    if (pwdata[`OCS_STAT_OVER]) next_oversample = 1'b0;
                    if (pwdata[`OCS_STAT_BUFDONE]) begin
                        next_buf_done_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        starve = level < (AW+1)'(n_listed(list_mask));
        case (state)
            OCS_IDLE: ;
            OCS_ARMED: begin
                if (stop_pending) begin
                    next_state = OCS_IDLE;
                end else if (trig_pulse) begin
                    // [R2] Trigger starts output
                    next_state = OCS_RUN;
                end
            end
            OCS_RUN: begin
                if (stop_pending && sample_idx == '0) begin
                    // [R4] Orderly stop at boundary
                    next_state = OCS_IDLE;
                end else if (tick && starve) begin
                    // [R6] Underflow on starved tick
                    next_underflow = 1'b1;
                    // [R3] Out of buffers ends run
                    if (!repeat_one_buffer_select && sample_idx == '0) begin
                        next_state = OCS_IDLE;
                    end
                end else if (tick) begin
                    next_ch = first_from(list_mask, 3'h0);
                    next_phase = 1'b0;
                    next_state = OCS_LOAD;
                end
            end
            OCS_LOAD: begin
                // [R8] Tick while loading
                if (tick) begin
                    next_oversample = 1'b1;
                end
                if (ch == 3'(NCH)) begin
                    // [R2] Simultaneous update
                    commit = 1'b1;
                    for (int i = 0; i < NCH; i++) begin
                        if (list_mask[i]) next_out_val[i] = shadow[i];
                    end
                    next_state = OCS_RUN;
                end else if (!phase) begin
                    next_phase = 1'b1;
                end else begin
                    pop = 1'b1;
                    next_shadow[ch] = ram_q;
                    next_ch = first_from(list_mask, ch + 3'h1);
                    next_phase = 1'b0;
                end
            end
            default: next_state = OCS_IDLE;
        endcase

        if (pop) begin
            buf_end = sample_idx + 1'b1 >= buf_len;
            next_sample_idx = buf_end ? '0 : sample_idx + 1'b1;
            // [R11] Waveform wraps to start
            next_rd_ptr = (buf_end && repeat_one_buffer_select)
                        ? '0 : rd_ptr + 1'b1;
            if (buf_end) begin
                // [R14] Buffer done event
                next_buffer_done_event = 1'b1;
                next_buf_done_flag = 1'b1;
            end
        end
        // [R12] Replay keeps waveform data
        next_level = level + (AW+1)'(push)
                   - (AW+1)'(pop && !repeat_one_buffer_select);
        // An emptied FIFO must not keep counting the discarded samples.
        if (flush) next_level = '0;

        if (next_state == OCS_IDLE) begin
            next_stop_pending = 1'b0;
        end
        // [R5] Abrupt stop wins
        if (abrupt) begin
            next_state = OCS_IDLE;
            next_stop_pending = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= OCS_IDLE;
            repeat_one_buffer_select <= 1'b0;
            trig_sel <= `OCS_TRIG_SW;
            clk_ext_sel <= 1'b0;
            list_mask <= `OCS_LIST_RST;
            pace_div <= `OCS_DIV_RST;
            buf_len <= (AW+1)'(`OCS_BUFLEN_RST);
            ch <= 3'h0;
            phase <= 1'b0;
            rd_ptr <= '0;
            wr_ptr <= '0;
            level <= '0;
            sample_idx <= '0;
            stop_pending <= 1'b0;
            underflow <= 1'b0;
            oversample <= 1'b0;
            buf_done_flag <= 1'b0;
            buffer_done_event <= 1'b0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            for (int i = 0; i < NCH; i++) begin
                shadow[i] <= 16'h0000;
                // [R13] Offset binary: mid code is 0 V
                out_val[i] <= 16'(1 << (DAC_WIDTH - 1));
            end
            // [R17] Digital lines low
            out_val[`OCS_CH_DIGITAL] <= `OCS_DOUT_RST;
        end else begin
            state <= next_state;
            repeat_one_buffer_select <= next_repeat;
            trig_sel <= next_trig_sel;
            clk_ext_sel <= next_clk_ext_sel;
            list_mask <= next_list_mask;
            pace_div <= next_pace_div;
            buf_len <= next_buf_len;
            ch <= next_ch;
            phase <= next_phase;
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            level <= next_level;
            sample_idx <= next_sample_idx;
            stop_pending <= next_stop_pending;
            underflow <= next_underflow;
            oversample <= next_oversample;
            buf_done_flag <= next_buf_done_flag;
            buffer_done_event <= next_buffer_done_event;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            shadow <= next_shadow;
            out_val <= next_out_val;
        end
    end

    // [R13] [R16] Straight code to pins
    assign analog_out_ch_zero  = out_val[0][DAC_WIDTH-1:0];
    assign analog_out_ch_one   = out_val[1][DAC_WIDTH-1:0];
    assign analog_out_ch_two   = out_val[2][DAC_WIDTH-1:0];
    assign analog_out_ch_three = out_val[3][DAC_WIDTH-1:0];
    assign digital_out         = out_val[`OCS_CH_DIGITAL];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_outputs_hold: assert property (!commit |=> $stable({ // [R7]
        analog_out_ch_zero, analog_out_ch_one, analog_out_ch_two,
        analog_out_ch_three, digital_out}))
        else $error("outputs changed outside a scan commit");
    a_scan_commit: assert property (commit && list_mask[4]
        |=> digital_out == $past(shadow[4])) // [R2]
        else $error("digital port missed scan value");
    a_underflow_set: assert property (state == OCS_RUN && tick && starve
        && !(stop_pending && sample_idx == '0) |=> underflow) // [R6]
        else $error("underflow not flagged");
    a_oversample_set: assert property (state == OCS_LOAD && tick
        |=> oversample) // [R8]
        else $error("over-sample not flagged");
    a_flag_latch: assert property (underflow && !wr |=> underflow) // [R20]
        else $error("underflow flag dropped");
    a_abrupt_stop: assert property (abrupt |=> state == OCS_IDLE) // [R5]
        else $error("abrupt stop did not halt");
    a_idle_ignores: assert property (state == OCS_IDLE && !wr
        |=> state == OCS_IDLE ##1 !commit) // [R4]
        else $error("trigger acted while stopped");
    a_wave_wrap: assert property (pop && buf_end
        && repeat_one_buffer_select |=> rd_ptr == '0) // [R11]
        else $error("waveform did not wrap");
    a_buffer_event: assert property (pop && buf_end
        |=> buffer_done_event ##1 !buffer_done_event) // [R14]
        else $error("buffer event not a single pulse");
    a_load_bound: assert property (disable iff (!presetn || abrupt) // [R3]
        state == OCS_RUN && tick && !starve
        && !stop_pending |=> state == OCS_LOAD ##[1:11] commit)
        else $error("scan load did not finish");

    c_wave_wrap: cover property (pop && buf_end && repeat_one_buffer_select);
    c_underflow: cover property (state == OCS_RUN && tick && starve);
    c_commit_all: cover property (commit && list_mask == 5'h1F);
    c_orderly: cover property (stop_pending ##1 state == OCS_IDLE);
endmodule
`default_nettype wire

/* File: inc/ocs_params.svh */
// Register offsets, field positions, reset values and sizes of the sequencer.
`ifndef OCS_PARAMS_SVH
`define OCS_PARAMS_SVH

`define OCS_FIFO_DEPTH   131072
`define OCS_NUM_CH       5
`define OCS_CH_DIGITAL   4

`define OCS_ADDR_CTRL    8'h00
`define OCS_ADDR_LIST    8'h04
`define OCS_ADDR_DIV     8'h08
`define OCS_ADDR_DATA    8'h0C
`define OCS_ADDR_BUFLEN  8'h10
`define OCS_ADDR_STATUS  8'h14
`define OCS_ADDR_LEVEL   8'h18

`define OCS_CTRL_START   0
`define OCS_CTRL_ORDERLY 1
`define OCS_CTRL_ABRUPT  2
`define OCS_CTRL_REPEAT  3
`define OCS_CTRL_TSEL    5:4
`define OCS_CTRL_CLKEXT  6
`define OCS_CTRL_FLUSH   7

`define OCS_STAT_RUN     0
`define OCS_STAT_ARMED   1
`define OCS_STAT_UNDER   2
`define OCS_STAT_OVER    3
`define OCS_STAT_BUFDONE 4
`define OCS_STAT_STOPREQ 5

`define OCS_TRIG_SW      2'h0
`define OCS_TRIG_RISE    2'h1
`define OCS_TRIG_FALL    2'h2

`define OCS_DIV_RST      32'h0000_0028
`define OCS_LIST_RST     5'h01
`define OCS_BUFLEN_RST   32'h0000_0400
`define OCS_DOUT_RST     16'h0000

`endif

/* File: inc/ocs_pkg.sv */
// Types shared by the output channel sequencer.
`default_nettype none
package ocs_pkg;
    typedef enum logic [1:0] {
        OCS_IDLE,
        OCS_ARMED,
        OCS_RUN,
        OCS_LOAD
    } ocs_state_type;
    typedef logic [15:0] ocs_sample_type;
endpackage
`default_nettype wire

/* File: verification/ocs_host_model.sv */
// Host model: APB master that feeds the sequencer registers.
`default_nettype none
module ocs_host_model (
    // Clock
    input  wire logic        pclk,
    // APB request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    // APB answer
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: verification/ocs_sequencer_tb_top.sv */
// Testbench: host-driven scans of the output channel sequencer.
`include "ocs_params.svh"
`default_nettype none
module ocs_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        ext_trigger, ext_clock, buffer_done_event, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] analog_out_ch_zero, analog_out_ch_one, analog_out_ch_two;
    logic [15:0] analog_out_ch_three, digital_out;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          n_event = 0;
    ocs_sequencer #(.FIFO_DEPTH(64)) ocs_sequencer_i (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .ext_trigger, .ext_clock, .analog_out_ch_zero,
        .analog_out_ch_one, .analog_out_ch_two, .analog_out_ch_three,
        .digital_out, .buffer_done_event);
    ocs_host_model ocs_host_model_i (.pclk, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr);
    task automatic chk(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ocs_host_model_i.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rdc(input string w, input logic [7:0] a, m, exp);
        ocs_host_model_i.xfer(1'b0, a, 32'h0, q, e);
        chk(w, q & {24'h0, m}, {24'h0, exp});
    endtask
    // Waits a bounded time for the port or channel three to show v.
    task automatic wait_for(input logic dig, input logic [15:0] v);
        for (int i = 0; i < 400; i++) begin
            @(posedge pclk);
            #1;
            if ((dig ? digital_out : analog_out_ch_three) === v) break;
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (buffer_done_event === 1'b1) n_event <= n_event + 1;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        presetn = 1'b0;
        ext_trigger = 1'b0;
        ext_clock = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("dout", {16'h0, digital_out}, 32'h0);
        chk("ch0", {16'h0, analog_out_ch_zero}, 32'h8000);
        rdc("list", `OCS_ADDR_LIST, 8'hFF, 8'h01);
        rdc("div", `OCS_ADDR_DIV, 8'hFF, 8'h28);
        rdc("hole", 8'h40, 8'hFF, 8'h00);
        chk("slverr", {31'h0, e}, 32'h1);
        wr(`OCS_ADDR_LIST, 32'h11);
        wr(`OCS_ADDR_DIV, 32'd20);
        wr(`OCS_ADDR_BUFLEN, 32'd2);
        // Interleaved by scan: channel zero first, then the port.
        wr(`OCS_ADDR_DATA, 32'h1111);
        wr(`OCS_ADDR_DATA, 32'hA5A5);
        wr(`OCS_ADDR_DATA, 32'h2222);
        wr(`OCS_ADDR_DATA, 32'h5A5A);
        wr(`OCS_ADDR_CTRL, 32'h01);
        wait_for(1'b1, 16'hA5A5);
        chk("scan1", {16'h0, analog_out_ch_zero}, 32'h1111);
        wait_for(1'b1, 16'h5A5A);
        chk("scan2", {16'h0, analog_out_ch_zero}, 32'h2222);
        repeat (100) @(posedge pclk);
        rdc("stat", `OCS_ADDR_STATUS, 8'h3F, 8'h14);
        rdc("stat", `OCS_ADDR_STATUS, 8'h3F, 8'h14);
        chk("hold", {analog_out_ch_zero, digital_out}, 32'h2222_5A5A);
        chk("ch12", {analog_out_ch_one, analog_out_ch_two}, 32'h8000_8000);
        chk("events", n_event, 32'd2);
        wr(`OCS_ADDR_STATUS, 32'h1C);
        rdc("clear", `OCS_ADDR_STATUS, 8'h3F, 8'h00);
        wr(`OCS_ADDR_CTRL, 32'h80);
        wr(`OCS_ADDR_LIST, 32'h08);
        // Waveform of two samples on one channel.
        wr(`OCS_ADDR_DATA, 32'h0123);
        wr(`OCS_ADDR_DATA, 32'h0FED);
        wr(`OCS_ADDR_CTRL, 32'h19);
        repeat (30) @(posedge pclk);
        rdc("armed", `OCS_ADDR_STATUS, 8'h03, 8'h02);
        chk("idle3", {16'h0, analog_out_ch_three}, 32'h8000);
        ext_trigger <= 1'b1;
        wait_for(1'b0, 16'h0123);
        wait_for(1'b0, 16'h0FED);
        wait_for(1'b0, 16'h0123);
        chk("wrap", {16'h0, analog_out_ch_three}, 32'h0123);
        rdc("level", `OCS_ADDR_LEVEL, 8'hFF, 8'h02);
        // Abrupt stop with the falling edge selected as trigger.
        wr(`OCS_ADDR_CTRL, 32'h24);
        rdc("abrupt", `OCS_ADDR_STATUS, 8'h03, 8'h00);
        ext_trigger <= 1'b0;
        repeat (3) @(posedge pclk);
        ext_trigger <= 1'b1;
        repeat (30) @(posedge pclk);
        rdc("ignored", `OCS_ADDR_STATUS, 8'h03, 8'h00);
        wr(`OCS_ADDR_LIST, 32'h08);
        wr(`OCS_ADDR_DIV, 32'd1);
        wr(`OCS_ADDR_CTRL, 32'h09);
        repeat (40) @(posedge pclk);
        rdc("over", `OCS_ADDR_STATUS, 8'h08, 8'h08);
        wr(`OCS_ADDR_CTRL, 32'h0A);
        repeat (20) @(posedge pclk);
        rdc("orderly", `OCS_ADDR_STATUS, 8'h23, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
